/* File: rtl/tsup_irq.sv */
// Sticky event status, enable mask and interrupt level of the timeout supervisor
`timescale 1ns/10ps
module tsup_irq
    import tsup_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic [tsup_pkg::EV_W-1:0] ev_set,
    input  wire logic                     clr_wr,
    input  wire logic [tsup_pkg::EV_W-1:0] clr_data,
    input  wire logic                     en_wr,
    input  wire logic [tsup_pkg::EV_W-1:0] en_data,
    output logic      [tsup_pkg::EV_W-1:0] status_r,
    output logic      [tsup_pkg::EV_W-1:0] enable_r,
    output logic                          irq_r
);

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= EV_RESET;
        end else begin
            status_r <= (status_r & ~(clr_wr ? clr_data : EV_RESET)) | ev_set;
        end
    end

    // Enable mask
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= EV_RESET;
        end else if (en_wr) begin
            enable_r <= en_data;
        end
    end

    // Level interrupt while any enabled bit is set
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & enable_r);
        end
    end

endmodule : tsup_irq

/* File: rtl/tsup_pkg.sv */
// Shared constants, field layouts, helper functions and state type of the timeout supervisor
package tsup_pkg;

    // Bus geometry
    localparam int          ADDR_W          = 20;
    localparam int          DATA_W          = 32;
    localparam int          STRB_W          = 4;

    // Register indexes; the byte address is four times the index
    localparam logic [15:0] IDX_CONTROL     = 16'hf020;
    localparam logic [15:0] IDX_PRESC       = 16'hf021;
    localparam logic [15:0] IDX_WRAP        = 16'hf022;
    localparam logic [15:0] IDX_COUNT       = 16'hf023;
    localparam logic [15:0] IDX_TRIGGERED   = 16'hf024;
    localparam logic [15:0] IDX_INT_STATUS  = 16'hf028;
    localparam logic [15:0] IDX_INT_CLEAR   = 16'hf029;
    localparam logic [15:0] IDX_INT_ENABLE  = 16'hf02a;

    // Field positions and widths
    localparam int          CTL_COUNT_BIT   = 0;
    localparam int          CTL_ARM_BIT     = 1;
    localparam int          TRIG_FLAG_BIT   = 0;
    localparam int          PRESC_W         = 16;
    localparam int          COUNT_W         = 12;
    localparam int          EV_W            = 2;
    localparam int          EV_EXPIRE_BIT   = 0;
    localparam int          EV_WRAP_BIT     = 1;

    // Reset values
    localparam logic [PRESC_W-1:0] WRAP_RESET  = 16'hffff;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 12'hfff;
    localparam logic [EV_W-1:0]    EV_RESET    = 2'h0;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Length of the chip reset pulse
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          CHIP_RESET_NS   = 1000;
    localparam int          FIRE_W          = 6;
    localparam logic [FIRE_W-1:0] FIRE_CYCLES =
        FIRE_W'((CHIP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Supervisor states, Gray coded along idle, count, fire
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_COUNT = 2'h1,
        ST_FIRE  = 2'h3
    } tsup_state_t;

    // True when a byte address selects the word at a register index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
        return addr[ADDR_W-1:2] == {2'h0, idx};
    endfunction : reg_hit

    // Merges written bytes into an old word under the byte strobes
    function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

endpackage : tsup_pkg

/* File: rtl/tsup_sync2.sv */
// Two flip-flop synchroniser for the oscillator pin
`timescale 1ns/10ps
module tsup_sync2 (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic d,
    output logic      q
);

    logic meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : tsup_sync2

/* File: rtl/tsup_top.sv */
// Timeout supervisor: oscillator prescaler, timeout down-counter, chip reset and AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// What this block does
// [RULE1] After reset the supervisor neither counts nor can reset the chip, both control bits being clear.
// [RULE2] Control bit 0 lets the prescaler and timeout counter advance; when clear nothing counts.
// [RULE3] Control bit 1 arms expiry to reset the chip; when clear the unit counts without resetting.
// [RULE4] The 16-bit prescaler adds one on each oscillator input rising edge while counting is on.
// [RULE5] When the prescaler equals the limit it returns to zero and the timeout counter drops by one.
// [RULE6] Software can read the current prescaler value as a read-only field for use as a time base.
// [RULE7] The 16-bit divider limit makes the timeout counter step once per limit plus one input edges.
// [RULE8] The 12-bit timeout counter counts down once per prescaler period and resets the chip at zero when armed.
// [RULE9] Software must rewrite the timeout counter with a nonzero value before it runs out.
// [RULE10] Unused bits of the five supervisor registers read as zero and ignore writes.
// [RULE11] A read-only flag goes to one when the supervisor resets the chip and only power-on clears it.
// [RULE12] A write to the timeout counter loads at once, and the counter holds at zero rather than wrap.
// [RULE13] The oscillator input is brought safely into the register clock domain before any logic uses it.
module tsup_top
    import tsup_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         reset_n,
    input  wire logic                         crystal_input_pin,
    input  wire logic [tsup_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [tsup_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [tsup_pkg::STRB_W-1:0]  s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [tsup_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [tsup_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic                              chip_reset,
    output logic                              irq
);
    import tsup_pkg::*;

    // Bus side state
    logic [ADDR_W-1:0]   awaddr_r;
    logic [DATA_W-1:0]   wdata_r;
    logic [STRB_W-1:0]   wstrb_r;
    logic                aw_free_r;
    logic                w_free_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;
    logic                ar_free_r;
    logic                rvalid_r;
    logic [1:0]          rresp_r;
    logic [DATA_W-1:0]   rdata_r;

    // Supervisor state
    logic                ctl_count_r;
    logic                ctl_arm_r;
    logic [PRESC_W-1:0]  presc_r;
    logic [PRESC_W-1:0]  wrap_r;
    logic [COUNT_W-1:0]  count_r;
    logic                triggered_r;
    tsup_state_t         state_r;
    logic [FIRE_W-1:0]   fire_cnt_r;
    logic                chip_reset_r;
    logic                xin_sync;
    logic                xin_prev_r;

    // Interrupt block outputs
    logic [EV_W-1:0]     int_status;
    logic [EV_W-1:0]     int_enable;
    logic                irq_r;

    // Combinational terms
    logic                do_write;
    logic                wr_ctl;
    logic                wr_wrap;
    logic                wr_count;
    logic                wr_int_clr;
    logic                wr_int_en;
    logic                wr_known;
    logic [DATA_W-1:0]   wr_word;
    logic                xin_edge;
    logic                run;
    logic                wrap_evt;
    logic                fire_start;
    logic [EV_W-1:0]     ev_set;
    logic [DATA_W-1:0]   rd_word;
    logic                rd_known;

    // Oscillator pin crosses into mclk before use
    tsup_sync2 u_xin_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .d       (crystal_input_pin),
        .q       (xin_sync)
    );

    // Remembers the synchronised level to find rising edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            xin_prev_r <= 1'b0;
        end else begin
            xin_prev_r <= xin_sync;
        end
    end

    // One-cycle pulse per oscillator rising edge
    assign xin_edge = xin_sync & ~xin_prev_r;  // [RULE13]

    // Write address channel: hold one address until the write completes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_free_r <= 1'b1;
            awaddr_r  <= '0;
        end else if (aw_free_r && s_axi_awvalid) begin
            aw_free_r <= 1'b0;
            awaddr_r  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_free_r <= 1'b1;
        end
    end

    // Write data channel: taken independently of the address
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            w_free_r <= 1'b1;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (w_free_r && s_axi_wvalid) begin
            w_free_r <= 1'b0;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (do_write) begin
            w_free_r <= 1'b1;
        end
    end

    // Write happens once both halves are held and no response is pending
    assign do_write   = !aw_free_r && !w_free_r && !bvalid_r;
    assign wr_ctl     = do_write && reg_hit(awaddr_r, IDX_CONTROL);
    assign wr_wrap    = do_write && reg_hit(awaddr_r, IDX_WRAP);
    assign wr_count   = do_write && reg_hit(awaddr_r, IDX_COUNT);
    assign wr_int_clr = do_write && reg_hit(awaddr_r, IDX_INT_CLEAR);
    assign wr_int_en  = do_write && reg_hit(awaddr_r, IDX_INT_ENABLE);
    assign wr_known   = reg_hit(awaddr_r, IDX_CONTROL) || reg_hit(awaddr_r, IDX_PRESC)
                     || reg_hit(awaddr_r, IDX_WRAP) || reg_hit(awaddr_r, IDX_COUNT)
                     || reg_hit(awaddr_r, IDX_TRIGGERED) || reg_hit(awaddr_r, IDX_INT_STATUS)
                     || reg_hit(awaddr_r, IDX_INT_CLEAR) || reg_hit(awaddr_r, IDX_INT_ENABLE);

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data selection; reserved bits are zero
    always_comb begin
        rd_word  = '0;
        rd_known = 1'b1;
        if (reg_hit(s_axi_araddr, IDX_CONTROL)) begin
            rd_word[CTL_COUNT_BIT] = ctl_count_r;  // [RULE10]
            rd_word[CTL_ARM_BIT]   = ctl_arm_r;
        end else if (reg_hit(s_axi_araddr, IDX_PRESC)) begin
            rd_word[PRESC_W-1:0] = presc_r;  // [RULE6]
        end else if (reg_hit(s_axi_araddr, IDX_WRAP)) begin
            rd_word[PRESC_W-1:0] = wrap_r;
        end else if (reg_hit(s_axi_araddr, IDX_COUNT)) begin
            rd_word[COUNT_W-1:0] = count_r;
        end else if (reg_hit(s_axi_araddr, IDX_TRIGGERED)) begin
            rd_word[TRIG_FLAG_BIT] = triggered_r;
        end else if (reg_hit(s_axi_araddr, IDX_INT_STATUS)) begin
            rd_word[EV_W-1:0] = int_status;
        end else if (reg_hit(s_axi_araddr, IDX_INT_ENABLE)) begin
            rd_word[EV_W-1:0] = int_enable;
        end else if (reg_hit(s_axi_araddr, IDX_INT_CLEAR)) begin
            rd_word = '0;
        end else begin
            rd_known = 1'b0;
        end
    end

    // Read channel: answer the cycle after the address is taken
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ar_free_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else if (ar_free_r && s_axi_arvalid) begin
            ar_free_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= rd_known ? RESP_OKAY : RESP_SLVERR;
            rdata_r   <= rd_word;
        end else if (rvalid_r && s_axi_rready) begin
            ar_free_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // Written word merged over the current control, limit or counter value, else over zero
    always_comb begin
        wr_word = wdata_r;
        if (reg_hit(awaddr_r, IDX_CONTROL)) begin
            wr_word = merge_strb({30'h0, ctl_arm_r, ctl_count_r}, wdata_r, wstrb_r);
        end else if (reg_hit(awaddr_r, IDX_WRAP)) begin
            wr_word = merge_strb({16'h0, wrap_r}, wdata_r, wstrb_r);
        end else if (reg_hit(awaddr_r, IDX_COUNT)) begin
            wr_word = merge_strb({20'h0, count_r}, wdata_r, wstrb_r);
        end else begin
            wr_word = merge_strb(32'h0, wdata_r, wstrb_r);
        end
    end

    // Control bits; cleared when the supervisor fires, as the chip reset would
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_count_r <= 1'b0;  // [RULE1]
            ctl_arm_r   <= 1'b0;
        end else if (fire_start) begin
            ctl_count_r <= 1'b0;
            ctl_arm_r   <= 1'b0;
        end else if (wr_ctl) begin
            ctl_count_r <= wr_word[CTL_COUNT_BIT];  // [RULE2]
            ctl_arm_r   <= wr_word[CTL_ARM_BIT];  // [RULE3]
        end
    end

    // Divider limit; upper bits are dropped
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrap_r <= WRAP_RESET;
        end else if (wr_wrap) begin
            wrap_r <= wr_word[PRESC_W-1:0];  // [RULE10]
        end
    end

    // Counting runs only while enabled and not firing
    assign run      = ctl_count_r && (state_r != ST_FIRE);  // [RULE2]
    assign wrap_evt = run && xin_edge && (presc_r == wrap_r);  // [RULE7]

    // Prescaler: count oscillator edges and wrap at the limit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            presc_r <= '0;
        end else if (wrap_evt) begin
            presc_r <= '0;  // [RULE5]
        end else if (run && xin_edge) begin
            presc_r <= presc_r + 16'h0001;  // [RULE4]
        end
    end

    // Timeout counter: software load wins, otherwise step down and hold at zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= COUNT_RESET;
        end else if (wr_count) begin
            count_r <= wr_word[COUNT_W-1:0];  // [RULE12]
        end else if (wrap_evt && (count_r != 12'h000)) begin
            count_r <= count_r - 12'h001;  // [RULE8]
        end
    end

    // Expiry while armed starts the chip reset
    assign fire_start = (state_r == ST_COUNT) && ctl_count_r && ctl_arm_r
                     && (count_r == 12'h000);  // [RULE8] [RULE3]

    // Supervisor sequencing
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (ctl_count_r) begin
                        state_r <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (fire_start) begin
                        state_r <= ST_FIRE;
                    end else if (!ctl_count_r) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_FIRE: begin
                    if (fire_cnt_r == FIRE_W'(1)) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Chip reset pulse length
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fire_cnt_r <= '0;
        end else if (fire_start) begin
            fire_cnt_r <= FIRE_CYCLES;
        end else if (fire_cnt_r != '0) begin
            fire_cnt_r <= fire_cnt_r - FIRE_W'(1);
        end
    end

    // Registered chip reset output
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            chip_reset_r <= 1'b0;
        end else begin
            chip_reset_r <= fire_start || (fire_cnt_r > FIRE_W'(1));  // [RULE8]
        end
    end

    // Triggered flag; only the power-on reset clears it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            triggered_r <= 1'b0;
        end else if (fire_start) begin
            triggered_r <= 1'b1;  // [RULE11]
        end
    end

    // Events: counter reaching zero, prescaler wrap
    always_comb begin
        ev_set                = EV_RESET;
        ev_set[EV_EXPIRE_BIT] = wrap_evt && (count_r == 12'h001) && !wr_count;
        ev_set[EV_WRAP_BIT]   = wrap_evt;
    end

    // Interrupt status and mask
    tsup_irq u_irq (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .ev_set   (ev_set),
        .clr_wr   (wr_int_clr),
        .clr_data (wr_word[EV_W-1:0]),
        .en_wr    (wr_int_en),
        .en_data  (wr_word[EV_W-1:0]),
        .status_r (int_status),
        .enable_r (int_enable),
        .irq_r    (irq_r)
    );

    // Port drivers, all from flip-flops
    assign s_axi_awready = aw_free_r;
    assign s_axi_wready  = w_free_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ar_free_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign chip_reset    = chip_reset_r;
    assign irq           = irq_r;

endmodule : tsup_top

/* File: verification/timeout_supervisor_test.sv */
// Self-checking bench of the timeout supervisor
`timescale 1ns/10ps
module timeout_supervisor_test;
    import tsup_pkg::*;
    logic              mclk, reset_n, pin, chip_reset, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [STRB_W-1:0] wstrb;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp, rsp;
    int                err_total, n_checks, seed, lim, cnt, presc, run;
    tsup_top uut (.mclk, .reset_n, .crystal_input_pin(pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_reset, .irq);
    // Main clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // Bus write, address and data offered together
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic a_ok, w_ok;
        awaddr <= ADDR_W'({idx, 2'h0});
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        a_ok = 1'b0;
        w_ok = 1'b0;
        while (!(a_ok && w_ok)) begin
            @(posedge mclk);
            if (!a_ok && awready === 1'b1) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        repeat ($random(seed) & 2) @(posedge mclk);
        bready <= 1'b1;
        do @(posedge mclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr
    // Bus read compared with expected data and response
    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
        araddr <= ADDR_W'({idx, 2'h0});
        arvalid <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat ($random(seed) & 2) @(posedge mclk);
        rready <= 1'b1;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, er});
    endtask : rdc
    // Oscillator edges, each stepping the model
    task automatic tick(input int n);
        repeat (n) begin
            pin <= 1'b1;
            repeat (3) @(posedge mclk);
            pin <= 1'b0;
            repeat (3) @(posedge mclk);
            if (run != 0 && presc == lim) begin
                presc = 0;
                if (cnt > 0) cnt--;
            end else if (run != 0) presc++;
        end
    endtask : tick
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        final_report();
    end
    // Main sequence
    initial begin
        {pin, reset_n, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wdata, err_total, n_checks, presc, run} = '0;
        wstrb = 4'hf;
        seed = 32'h852e0273;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdc(IDX_CONTROL, 32'h0, RESP_OKAY);
        rdc(IDX_WRAP, {16'h0, WRAP_RESET}, RESP_OKAY);
        rdc(IDX_COUNT, {20'h0, COUNT_RESET}, RESP_OKAY);
        check({31'h0, chip_reset}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(IDX_WRAP, v);
            rdc(IDX_WRAP, v & 32'hffff, RESP_OKAY);
            wr(IDX_COUNT, v);
            rdc(IDX_COUNT, v & 32'hfff, RESP_OKAY);
            wr(IDX_PRESC, v);
            rdc(IDX_PRESC, 32'h0, RESP_OKAY);
            wr(IDX_CONTROL, v & 32'hfffffffc);
            rdc(IDX_CONTROL, 32'h0, RESP_OKAY);
        end
        wr(16'hf02f, 32'h1);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rdc(16'hf02f, 32'h0, RESP_SLVERR);
        lim = 3;
        cnt = 2;
        wr(IDX_WRAP, 32'(lim));
        wr(IDX_COUNT, 32'(cnt));
        wr(IDX_INT_ENABLE, 32'h1);
        tick(2);
        rdc(IDX_PRESC, 32'(presc), RESP_OKAY);
        wr(IDX_CONTROL, 32'h1);
        run = 1;
        tick(2);
        rdc(IDX_PRESC, 32'(presc), RESP_OKAY);
        tick(2);
        rdc(IDX_COUNT, 32'(cnt), RESP_OKAY);
        tick(8);
        rdc(IDX_COUNT, 32'(cnt), RESP_OKAY);
        check({31'h0, chip_reset}, 32'h0);
        rdc(IDX_INT_STATUS, 32'h3, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        wr(IDX_INT_CLEAR, 32'h1);
        repeat (2) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        cnt = 1;
        wr(IDX_COUNT, 32'(cnt));
        wr(IDX_CONTROL, 32'h3);
        while (cnt > 0) tick(1);
        for (int i = 0; i < 20 && chip_reset !== 1'b1; i++) @(posedge mclk);
        check({31'h0, chip_reset}, 32'h1);
        run = 0;
        rdc(IDX_CONTROL, 32'h0, RESP_OKAY);
        rdc(IDX_TRIGGERED, 32'h1, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        repeat (25) @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdc(IDX_TRIGGERED, 32'h0, RESP_OKAY);
        final_report();
    end
endmodule : timeout_supervisor_test

/* File: verification/tsup_top_asserts.sv */
// Port-level assertions of the timeout supervisor
`timescale 1ns/10ps
module tsup_top_asserts (
    input wire logic                        mclk,
    input wire logic                        reset_n,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [tsup_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic                        chip_reset
);
    import tsup_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [5:0] pulse_r;
    // Counts the cycles of the current chip reset pulse
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_r <= 6'h0;
        end else if (chip_reset) begin
            pulse_r <= pulse_r + 6'h1;
        end else begin
            pulse_r <= 6'h0;
        end
    end
    // Address and data taken together, and a read address taken
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write not answered on time");
    chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered on time");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    chk_pulse_len: assert property ($fell(chip_reset) |-> pulse_r == FIRE_CYCLES)
        else $error("chip reset pulse of wrong length");
    chk_pulse_max: assert property (pulse_r <= FIRE_CYCLES)
        else $error("chip reset pulse too long");
    chk_no_refire: assert property ($fell(chip_reset) |=> !chip_reset [*8])
        else $error("supervisor fired again without rearming");
endmodule : tsup_top_asserts

bind tsup_top tsup_top_asserts u_chk (.mclk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_reset);
